// ===== verilog/nct_core.sv
`timescale 1ns/10ps
// Operation
// - Duration is op cycles plus bus cycles
// - Verify all blocks: 1850 bus cycles
// - Verify flash block: 1559 bus cycles
// - Verify EEPROM block: 682 bus cycles
// - Verify flash section: 494 bus cycles
// - Verify EEPROM section: 555 bus cycles
// - Flash two words: 68 op, 1407 bus
// - Flash four words: 122 op, 2138 bus
// - EEPROM one byte: 47 op, 1371 bus
// - EEPROM two bytes: 94 op, 2120 bus
// - EEPROM three bytes: 141 op, 2869 bus
// - EEPROM four bytes: 188 op, 3618 bus
// - Backdoor key check: 464 bus cycles
// - Margin load: 413 bus cycles
module nct_core (
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic OP_TICK,
   input wire logic START,
   input wire logic [3:0] CMD,
   input wire logic DONE_CLR,
   output logic BUSY,
   output logic DONE,
   output logic CMD_ERR
);
   // =====================================================
   // Command decode
   logic [11:0] bus_len;
   logic [7:0] op_len;
   logic legal;
   always_comb begin
      legal = 1'b1;
      op_len = nct_pkg::OP_NONE;
      bus_len = nct_pkg::BUS_VFY_ALL;
      unique case (CMD)
         nct_pkg::CMD_VFY_ALL: bus_len = nct_pkg::BUS_VFY_ALL;
         nct_pkg::CMD_VFY_FBLK: bus_len = nct_pkg::BUS_VFY_FBLK;
         nct_pkg::CMD_VFY_EBLK: bus_len = nct_pkg::BUS_VFY_EBLK;
         nct_pkg::CMD_VFY_FSEC: bus_len = nct_pkg::BUS_VFY_FSEC;
         nct_pkg::CMD_VFY_ESEC: bus_len = nct_pkg::BUS_VFY_ESEC;
         nct_pkg::CMD_PGM_F2: begin
            bus_len = nct_pkg::BUS_PGM_F2;
            op_len = nct_pkg::OP_PGM_F2;
         end
         nct_pkg::CMD_PGM_F4: begin
            bus_len = nct_pkg::BUS_PGM_F4;
            op_len = nct_pkg::OP_PGM_F4;
         end
         nct_pkg::CMD_PGM_E1: begin
            bus_len = nct_pkg::BUS_PGM_E1;
            op_len = nct_pkg::OP_PGM_E1;
         end
         nct_pkg::CMD_PGM_E2: begin
            bus_len = nct_pkg::BUS_PGM_E2;
            op_len = nct_pkg::OP_PGM_E2;
         end
         nct_pkg::CMD_PGM_E3: begin
            bus_len = nct_pkg::BUS_PGM_E3;
            op_len = nct_pkg::OP_PGM_E3;
         end
         nct_pkg::CMD_PGM_E4: begin
            bus_len = nct_pkg::BUS_PGM_E4;
            op_len = nct_pkg::OP_PGM_E4;
         end
         nct_pkg::CMD_VFY_KEY: bus_len = nct_pkg::BUS_VFY_KEY;
         nct_pkg::CMD_MARGIN: bus_len = nct_pkg::BUS_MARGIN;
         default: legal = 1'b0;
      endcase
   end

   // =====================================================
   // Sequencer: bus phase then operation-clock phase
   nct_pkg::nct_state_t state_reg;
   logic [11:0] bus_cnt_reg;
   logic [7:0] op_cnt_reg;
   logic launch;
   logic finish;
   // Only an idle sequencer accepts a launch; a busy one drops START silently
   assign launch = START && legal && (state_reg == nct_pkg::ST_IDLE);
   assign finish = ((state_reg == nct_pkg::ST_BUS) && bus_cnt_reg == 12'h001 && op_cnt_reg == 8'h00)
      || ((state_reg == nct_pkg::ST_OP) && OP_TICK && op_cnt_reg == 8'h01);

   // Ticks in the bus phase are dropped: the operation phase starts only after the last bus cycle
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state_reg <= nct_pkg::ST_IDLE;
         bus_cnt_reg <= 12'h000;
         op_cnt_reg <= 8'h00;
      end else begin
         unique case (state_reg)
            nct_pkg::ST_IDLE: begin
               if (launch) begin
                  state_reg <= nct_pkg::ST_BUS;
                  bus_cnt_reg <= bus_len;
                  op_cnt_reg <= op_len;
               end
            end
            nct_pkg::ST_BUS: begin
               bus_cnt_reg <= bus_cnt_reg - 12'h001;
               if (bus_cnt_reg == 12'h001) begin
                  state_reg <= (op_cnt_reg == 8'h00) ? nct_pkg::ST_IDLE : nct_pkg::ST_OP;
               end
            end
            nct_pkg::ST_OP: begin
               if (OP_TICK) begin
                  op_cnt_reg <= op_cnt_reg - 8'h01;
                  if (op_cnt_reg == 8'h01) begin
                     state_reg <= nct_pkg::ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // =====================================================
   // Status outputs
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= (launch || state_reg != nct_pkg::ST_IDLE) && !finish;
      end
   end

   // Completion wins over a clear in the same cycle
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         DONE <= 1'b0;
      end else if (finish) begin
         DONE <= 1'b1;
      end else if (DONE_CLR || launch) begin
         DONE <= 1'b0;
      end
   end

   // A busy sequencer ignores START, so a bad code is flagged only while idle
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CMD_ERR <= 1'b0;
      end else if (START && state_reg == nct_pkg::ST_IDLE) begin
         CMD_ERR <= !legal;
      end
   end

   // =====================================================
   // Checks
   a_busy_on_launch: assert property (@(posedge REF_CLK) disable iff (!NRST)
      launch |=> BUSY) else $error("busy not raised after launch");
   a_busy_state: assert property (@(posedge REF_CLK) disable iff (!NRST)
      BUSY == (state_reg != nct_pkg::ST_IDLE)) else $error("busy and state disagree");
   a_vfy_all_len: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_VFY_ALL) |=> BUSY [*8]) else $error("verify all ended early");
   a_done_after_finish: assert property (@(posedge REF_CLK) disable iff (!NRST)
      finish |=> (DONE && !BUSY)) else $error("done not set at finish");
   a_busy_fall_done: assert property (@(posedge REF_CLK) disable iff (!NRST)
      $fell(BUSY) |-> DONE) else $error("busy fell without done");
   a_done_rise: assert property (@(posedge REF_CLK) disable iff (!NRST)
      $rose(DONE) |-> $past(finish)) else $error("done rose without finish");
   a_no_relaunch: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state_reg == nct_pkg::ST_BUS && START) |=> ($stable(op_cnt_reg) && $stable(CMD_ERR)))
      else $error("start taken while busy");
   a_cmd_err_set: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (START && state_reg == nct_pkg::ST_IDLE && !legal) |=> CMD_ERR) else $error("illegal code not flagged");
   a_bus_dec: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state_reg == nct_pkg::ST_BUS) |=> (bus_cnt_reg == $past(bus_cnt_reg) - 12'h001))
      else $error("bus counter stalled");
   a_op_entry: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state_reg == nct_pkg::ST_BUS && bus_cnt_reg == 12'h001 && op_cnt_reg != 8'h00) |=> (state_reg == nct_pkg::ST_OP))
      else $error("operation phase not entered");
   a_op_hold: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state_reg == nct_pkg::ST_OP && !OP_TICK) |=> $stable(op_cnt_reg)) else $error("op count moved");
   a_op_dec: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state_reg == nct_pkg::ST_OP && OP_TICK) |=> (op_cnt_reg == $past(op_cnt_reg) - 8'h01))
      else $error("op count missed a tick");

   // =====================================================
   // Counter loads: each launch must load the cycle counts of its own command
   a_vfy_all_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_VFY_ALL) |=> (bus_cnt_reg == 12'h73A && op_cnt_reg == 8'h00))
      else $error("verify all load wrong");
   a_vfy_fblk_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_VFY_FBLK) |=> (bus_cnt_reg == 12'h617 && op_cnt_reg == 8'h00))
      else $error("verify flash block load wrong");
   a_vfy_eblk_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_VFY_EBLK) |=> (bus_cnt_reg == 12'h2AA && op_cnt_reg == 8'h00))
      else $error("verify eeprom block load wrong");
   a_vfy_fsec_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_VFY_FSEC) |=> (bus_cnt_reg == 12'h1EE && op_cnt_reg == 8'h00))
      else $error("verify flash section load wrong");
   a_vfy_esec_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_VFY_ESEC) |=> (bus_cnt_reg == 12'h22B && op_cnt_reg == 8'h00))
      else $error("verify eeprom section load wrong");
   a_pgm_f2_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_PGM_F2) |=> (bus_cnt_reg == 12'h57F && op_cnt_reg == 8'h44))
      else $error("flash two word load wrong");
   a_pgm_f4_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_PGM_F4) |=> (bus_cnt_reg == 12'h85A && op_cnt_reg == 8'h7A))
      else $error("flash four word load wrong");
   a_pgm_op_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_PGM_E1) |=> (op_cnt_reg == 8'h2F && bus_cnt_reg == 12'h55B))
      else $error("eeprom byte load wrong");
   a_pgm_e2_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_PGM_E2) |=> (bus_cnt_reg == 12'h848 && op_cnt_reg == 8'h5E))
      else $error("eeprom two byte load wrong");
   a_pgm_e3_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_PGM_E3) |=> (bus_cnt_reg == 12'hB35 && op_cnt_reg == 8'h8D))
      else $error("eeprom three byte load wrong");
   a_pgm_e4_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_PGM_E4) |=> (bus_cnt_reg == 12'hE22 && op_cnt_reg == 8'hBC))
      else $error("eeprom four byte load wrong");
   a_key_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_VFY_KEY) |=> (bus_cnt_reg == 12'h1D0 && op_cnt_reg == 8'h00))
      else $error("key check load wrong");
   a_margin_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (launch && CMD == nct_pkg::CMD_MARGIN) |=> (bus_cnt_reg == 12'h19D && op_cnt_reg == 8'h00))
      else $error("margin load wrong");
endmodule

// ===== pkg/nct_pkg.sv
package nct_pkg;
   // Command codes
   localparam logic [3:0] CMD_VFY_ALL = 4'h0;
   localparam logic [3:0] CMD_VFY_FBLK = 4'h1;
   localparam logic [3:0] CMD_VFY_EBLK = 4'h2;
   localparam logic [3:0] CMD_VFY_FSEC = 4'h3;
   localparam logic [3:0] CMD_VFY_ESEC = 4'h4;
   localparam logic [3:0] CMD_PGM_F2 = 4'h5;
   localparam logic [3:0] CMD_PGM_F4 = 4'h6;
   localparam logic [3:0] CMD_PGM_E1 = 4'h7;
   localparam logic [3:0] CMD_PGM_E2 = 4'h8;
   localparam logic [3:0] CMD_PGM_E3 = 4'h9;
   localparam logic [3:0] CMD_PGM_E4 = 4'hA;
   localparam logic [3:0] CMD_VFY_KEY = 4'hB;
   localparam logic [3:0] CMD_MARGIN = 4'hC;
   // Bus-clock cycle counts
   localparam logic [11:0] BUS_VFY_ALL = 12'h73A;
   localparam logic [11:0] BUS_VFY_FBLK = 12'h617;
   localparam logic [11:0] BUS_VFY_EBLK = 12'h2AA;
   localparam logic [11:0] BUS_VFY_FSEC = 12'h1EE;
   localparam logic [11:0] BUS_VFY_ESEC = 12'h22B;
   localparam logic [11:0] BUS_PGM_F2 = 12'h57F;
   localparam logic [11:0] BUS_PGM_F4 = 12'h85A;
   localparam logic [11:0] BUS_PGM_E1 = 12'h55B;
   localparam logic [11:0] BUS_PGM_E2 = 12'h848;
   localparam logic [11:0] BUS_PGM_E3 = 12'hB35;
   localparam logic [11:0] BUS_PGM_E4 = 12'hE22;
   localparam logic [11:0] BUS_VFY_KEY = 12'h1D0;
   localparam logic [11:0] BUS_MARGIN = 12'h19D;
   // Operation-clock cycle counts
   localparam logic [7:0] OP_NONE = 8'h00;
   localparam logic [7:0] OP_PGM_F2 = 8'h44;
   localparam logic [7:0] OP_PGM_F4 = 8'h7A;
   localparam logic [7:0] OP_PGM_E1 = 8'h2F;
   localparam logic [7:0] OP_PGM_E2 = 8'h5E;
   localparam logic [7:0] OP_PGM_E3 = 8'h8D;
   localparam logic [7:0] OP_PGM_E4 = 8'hBC;
   typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_OP} nct_state_t;
endpackage

// ===== dv/test_nvm_command_timing.sv
`timescale 1ns/10ps
module test_nvm_command_timing;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic op_tick = 1'b0;
   logic start = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic done_clr = 1'b0;
   logic busy;
   logic done;
   logic cmd_err;
   int fails = 0;
   int total_checks = 0;

   nct_core i_dut (.REF_CLK(ref_clk), .NRST(nrst), .OP_TICK(op_tick), .START(start), .CMD(cmd),
      .DONE_CLR(done_clr), .BUSY(busy), .DONE(done), .CMD_ERR(cmd_err));

   // ==========================================
   // Clock, checking and closing
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // Scenarios
   task automatic launch(input logic [3:0] c);
      @(posedge ref_clk);
      start <= 1'b1;
      cmd <= c;
      @(posedge ref_clk);
      start <= 1'b0;
   endtask

   // Ticks also fall in the bus phase, its last cycle too, and must be ignored there
   task automatic run_cmd(input logic [3:0] c, input logic [15:0] nbus, input logic [15:0] nop);
      int i;
      int sent;
      int seen;
      int last;
      bit tk;
      i = 0;
      sent = 0;
      seen = 0;
      last = 0;
      launch(c);
      #1;
      while (i < 5000 && done !== 1'b1) begin
         @(posedge ref_clk);
         i++;
         if (op_tick === 1'b1 && i > nbus) begin
            seen++;
            last = i;
         end
         // Every fourth cycle, as a divided clock gives, plus both cycles around the phase change
         tk = ((i % 4 == 0) || (i == nbus - 1) || (i == nbus)) && ((i < nbus) || (sent < nop));
         sent += (tk && (i >= nbus));
         op_tick <= tk;
         // A second launch, with an illegal code, while counting must change nothing
         start <= (i == 1);
         cmd <= (i == 1) ? 4'hF : c;
         // Clear held high: completion must still win in its own cycle
         done_clr <= 1'b1;
         #1;
         if (done !== 1'b1) chk("busy", {15'h0, busy}, 16'h1);
      end
      chk("length", 16'(i), (nop == 16'h0) ? nbus : 16'(last));
      chk("ticks", 16'(seen), nop);
      chk("busy end", {15'h0, busy}, 16'h0);
      chk("done", {15'h0, done}, 16'h1);
      chk("cmd err", {15'h0, cmd_err}, 16'h0);
   endtask

   // Reset while a program command counts must drop every output at once
   task automatic reset_mid();
      launch(nct_pkg::CMD_PGM_F2);
      repeat (20) @(posedge ref_clk);
      #1;
      chk("busy pre", {15'h0, busy}, 16'h1);
      @(posedge ref_clk);
      nrst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("reset mid", {13'h0, busy, done, cmd_err}, 16'h0);
      @(posedge ref_clk);
      nrst <= 1'b1;
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      #1;
      chk("reset", {13'h0, busy, done, cmd_err}, 16'h0);
      launch(4'hD);
      #1;
      chk("illegal", {14'h0, busy, cmd_err}, 16'h1);
      reset_mid();
      run_cmd(nct_pkg::CMD_VFY_ALL, 16'h073A, 16'h0000);
      run_cmd(nct_pkg::CMD_VFY_FBLK, 16'h0617, 16'h0000);
      run_cmd(nct_pkg::CMD_VFY_EBLK, 16'h02AA, 16'h0000);
      run_cmd(nct_pkg::CMD_VFY_FSEC, 16'h01EE, 16'h0000);
      run_cmd(nct_pkg::CMD_VFY_ESEC, 16'h022B, 16'h0000);
      run_cmd(nct_pkg::CMD_PGM_F2, 16'h057F, 16'h0044);
      run_cmd(nct_pkg::CMD_PGM_F4, 16'h085A, 16'h007A);
      run_cmd(nct_pkg::CMD_PGM_E1, 16'h055B, 16'h002F);
      run_cmd(nct_pkg::CMD_PGM_E2, 16'h0848, 16'h005E);
      run_cmd(nct_pkg::CMD_PGM_E3, 16'h0B35, 16'h008D);
      run_cmd(nct_pkg::CMD_PGM_E4, 16'h0E22, 16'h00BC);
      run_cmd(nct_pkg::CMD_VFY_KEY, 16'h01D0, 16'h0000);
      run_cmd(nct_pkg::CMD_MARGIN, 16'h019D, 16'h0000);
      @(posedge ref_clk);
      done_clr <= 1'b1;
      @(posedge ref_clk);
      done_clr <= 1'b0;
      #1;
      chk("done clr", {15'h0, done}, 16'h0);
      final_report();
   end

   // Whole run is about 22000 cycles; the limit of 50000 cycles is over twice that
   initial begin
      #500000;
      fails++;
      final_report();
   end
endmodule
